// [rtl/poc_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Offset calibration sequencer: search, averaging, baseline
// ------------------------------------------------------------
module poc_top #(
    parameter logic [13:0] ADC_TARGET = 14'h00FF  // Search target, plain default
) (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST_B,
    // Register port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // Conversion results, same clock
    input wire logic ADC_VALID,
    input wire logic [13:0] ADC_DATA,
    // Loose control and status
    input wire logic CAL_IRQ_EN,
    input wire logic FLAG_CLR,
    output logic CAL_DONE,
    output logic OFFSET_LOWERED,
    output logic CAL_IRQ,
    // Results
    output logic [7:0] OFFSET,
    output logic [13:0] PROX_BASELINE
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    poc_pkg::poc_state_t state_reg;      // Sequencer state
    poc_pkg::poc_state_t state_next;     // Next sequencer state
    logic [7:0] cfg_reg;                 // Averaging configuration
    logic [2:0] bit_idx_reg;             // Offset bit under trial
    logic [7:0] cnt_reg;                 // Results still to average
    logic [7:0] ofs_next;                // Offset after search step
    logic [13:0] avg_value;              // Sum shifted down
    logic [2:0] avg_sel;                 // Averaging count field
    logic wr_ctrl;                       // Write to control register
    logic start;                         // Go written as one
    logic stop;                          // Go written as zero
    logic skip;                          // Search skip bit
    logic zero_trim;                     // Zero trim bit
    logic load_avg;                      // Load baseline bit
    logic search_last;                   // Last search step taken
    logic avg_last;                      // Last averaged result taken
    logic zero_hit;                      // Zero result while averaging
    poc_acc_if acc_bus();                // Accumulator carrier

    // Number of results for a count code
    function automatic logic [7:0] avg_len(input logic [2:0] sel);
        avg_len = 8'h01 << sel;
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign avg_sel = cfg_reg[poc_pkg::AVG_SEL_MSB:poc_pkg::AVG_SEL_LSB];
    assign skip = cfg_reg[poc_pkg::SKIP_SEARCH_BIT];
    assign zero_trim = cfg_reg[poc_pkg::ZERO_TRIM_BIT];
    assign load_avg = cfg_reg[poc_pkg::LOAD_AVG_BIT];
    assign wr_ctrl = REG_WR && (REG_ADDR == poc_pkg::ADDR_CAL_CTRL);
    assign start = wr_ctrl && REG_WDATA[poc_pkg::CAL_GO_BIT];
    assign stop = wr_ctrl && !REG_WDATA[poc_pkg::CAL_GO_BIT];
    assign search_last = (state_reg == poc_pkg::ST_SEARCH) && ADC_VALID
                         && (bit_idx_reg == 3'h0);
    assign avg_last = (state_reg == poc_pkg::ST_AVG) && ADC_VALID && (cnt_reg == 8'h01);
    assign zero_hit = (state_reg == poc_pkg::ST_AVG) && ADC_VALID
                      && (ADC_DATA == 14'h0000) && zero_trim;
    // Divide by the power-of-two count; the sum is never wider than 14+sel bits
    assign avg_value = 14'(acc_bus.sum >> avg_sel);

    // Search step: a result below target means too much offset, drop the bit
    always_comb begin
        ofs_next = OFFSET;
        if (ADC_DATA < ADC_TARGET) begin
            ofs_next[bit_idx_reg] = 1'b0;
        end
        if (bit_idx_reg != 3'h0) begin
            ofs_next = ofs_next | (8'h01 << (bit_idx_reg - 3'h1));
        end
    end

    // ------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------
    assign acc_bus.clr = (state_reg != poc_pkg::ST_AVG);
    assign acc_bus.add = (state_reg == poc_pkg::ST_AVG) && ADC_VALID;
    assign acc_bus.din = ADC_DATA;

    poc_acc poc_acc_i (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .bus(acc_bus)
    );

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Stop beats everything so a zero write halts mid-step
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            poc_pkg::ST_IDLE: begin
                if (start && skip) begin
                    // Straight to averaging, or done if none asked
                    state_next = (avg_sel == 3'h0) ? poc_pkg::ST_FINISH
                                                   : poc_pkg::ST_AVG;
                end else if (start) begin
                    state_next = poc_pkg::ST_SEARCH;
                end
            end
            poc_pkg::ST_SEARCH: begin
                if (search_last) begin
                    // Averaging waits for the search to end
                    state_next = (avg_sel == 3'h0) ? poc_pkg::ST_FINISH
                                                   : poc_pkg::ST_AVG;
                end
            end
            poc_pkg::ST_AVG: begin
                // A trim does not restart the run
                if (avg_last) begin
                    state_next = poc_pkg::ST_FINISH;
                end
            end
            poc_pkg::ST_FINISH: begin
                state_next = poc_pkg::ST_IDLE;
            end
            default: begin
                state_next = poc_pkg::ST_IDLE;
            end
        endcase
        if (stop) begin
            state_next = poc_pkg::ST_IDLE;
        end
    end

    // State register
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= poc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Search bit index and average count
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            bit_idx_reg <= poc_pkg::SEARCH_TOP;
            cnt_reg <= 8'h00;
        end else begin
            if (state_reg == poc_pkg::ST_IDLE) begin
                bit_idx_reg <= poc_pkg::SEARCH_TOP;
            end else if ((state_reg == poc_pkg::ST_SEARCH) && ADC_VALID) begin
                bit_idx_reg <= bit_idx_reg - 3'h1;
            end
            if ((state_next == poc_pkg::ST_AVG) && (state_reg != poc_pkg::ST_AVG)) begin
                cnt_reg <= avg_len(avg_sel);
            end else if ((state_reg == poc_pkg::ST_AVG) && ADC_VALID) begin
                cnt_reg <= cnt_reg - 8'h01;
            end
        end
    end

    // Offset: search probes, then zero trims; saturates at zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            OFFSET <= 8'h00;
        end else if (stop) begin
            OFFSET <= OFFSET;
        end else if (start && !skip && (state_reg == poc_pkg::ST_IDLE)) begin
            OFFSET <= poc_pkg::SEARCH_START;
        end else if ((state_reg == poc_pkg::ST_SEARCH) && ADC_VALID) begin
            OFFSET <= ofs_next;
        end else if (zero_hit && (OFFSET != 8'h00)) begin
            OFFSET <= OFFSET - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Flags, baseline, interrupt
    // ------------------------------------------------------------
    // Sticky flags: a set in the clear cycle wins
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CAL_DONE <= 1'b0;
            OFFSET_LOWERED <= 1'b0;
        end else begin
            if (state_reg == poc_pkg::ST_FINISH) begin
                CAL_DONE <= 1'b1;
            end else if (FLAG_CLR || start) begin
                CAL_DONE <= 1'b0;
            end
            if (zero_hit) begin
                OFFSET_LOWERED <= 1'b1;
            end else if (FLAG_CLR) begin
                OFFSET_LOWERED <= 1'b0;
            end
        end
    end

    // Interrupt follows the done flag when enabled
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            CAL_IRQ <= 1'b0;
        end else begin
            CAL_IRQ <= CAL_DONE && CAL_IRQ_EN;
        end
    end

    // Baseline load at end; a trimmed run may leave it biased
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            PROX_BASELINE <= 14'h0000;
        end else if ((state_reg == poc_pkg::ST_FINISH) && load_avg && (avg_sel != 3'h0)) begin
            PROX_BASELINE <= avg_value;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Configuration write; reserved bits stay zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            cfg_reg <= poc_pkg::AVG_CFG_RESET;
        end else if (REG_WR && (REG_ADDR == poc_pkg::ADDR_AVG_CFG)) begin
            cfg_reg <= REG_WDATA & poc_pkg::AVG_CFG_WMASK;
        end
    end

    // Read data; the go bit reads back as busy, unmapped reads zero
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            REG_RDATA <= 8'h00;
        end else if (REG_RD) begin
            if (REG_ADDR == poc_pkg::ADDR_CAL_CTRL) begin
                REG_RDATA <= (state_reg != poc_pkg::ST_IDLE) ? poc_pkg::CAL_CTRL_MASK : 8'h00;
            end else if (REG_ADDR == poc_pkg::ADDR_AVG_CFG) begin
                REG_RDATA <= cfg_reg;
            end else begin
                REG_RDATA <= 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_skip_search: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state_reg == poc_pkg::ST_IDLE && start && skip) |=> state_reg != poc_pkg::ST_SEARCH)
        else $error("search entered with skip set");
    a_avg_order: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state_reg == poc_pkg::ST_AVG && $past(state_reg) == poc_pkg::ST_IDLE) |->
        $past(skip))
        else $error("averaging began without search or skip");
    a_zero_trim: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (zero_hit && !stop && OFFSET != 8'h00) |=>
        (OFFSET == $past(OFFSET) - 8'h01) && OFFSET_LOWERED)
        else $error("zero result did not lower offset");
    a_trim_goes_on: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (zero_hit && !avg_last && !stop) |=> state_reg == poc_pkg::ST_AVG)
        else $error("averaging left after trim");
    a_load_base: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state_reg == poc_pkg::ST_FINISH && load_avg && avg_sel != 3'h0) |=>
        PROX_BASELINE == 14'($past(acc_bus.sum) >> $past(avg_sel)))
        else $error("baseline not loaded with average");
    a_avg_len: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state_reg == poc_pkg::ST_AVG && $past(state_reg) != poc_pkg::ST_AVG) |->
        cnt_reg == (8'h01 << avg_sel))
        else $error("wrong averaging length");
    a_done_irq: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        (state_reg == poc_pkg::ST_FINISH && CAL_IRQ_EN) |=> CAL_DONE ##1 CAL_IRQ)
        else $error("done or interrupt missing");
    a_stop_now: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
        stop |=> state_reg == poc_pkg::ST_IDLE && $stable(OFFSET))
        else $error("stop did not halt at once");
endmodule

// [rtl/poc_pkg.sv]
// What this block does
// - Load DC average into baseline at end
// - Zero result during averaging lowers offset, flags
// - Averaging continues after an automatic decrement
// - Skip bit omits the binary-search step
// - Count field: 0 skips, n averages 2^n
// - Averaging runs only after search ends/skipped
// - Write 1 starts; write 0 stops at once
// - Done flag at end; interrupt when enabled
package poc_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CAL_CTRL = 8'h69;   // Start/stop, busy readback
    localparam logic [7:0] ADDR_AVG_CFG = 8'h6A;    // Averaging configuration
    localparam logic [7:0] AVG_CFG_RESET = 8'h00;   // Configuration reset value
    localparam logic [7:0] CAL_CTRL_MASK = 8'h01;   // Only bit 0 is implemented
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CAL_GO_BIT = 0;           // Calibration go
    localparam int LOAD_AVG_BIT = 7;         // Load average to baseline
    localparam int ZERO_TRIM_BIT = 6;        // Zero trim during averaging
    localparam int SKIP_SEARCH_BIT = 3;      // Skip binary search
    localparam int AVG_SEL_MSB = 2;          // Averaging count field top
    localparam int AVG_SEL_LSB = 0;          // Averaging count field bottom
    localparam logic [7:0] AVG_CFG_WMASK = 8'hCF; // Bits 5:4 reserved, read zero
    // ------------------------------------------------------------
    // Widths and values
    // ------------------------------------------------------------
    localparam int ADC_W = 14;               // Result width
    localparam int OFS_W = 8;                // Offset width
    localparam int SUM_W = 21;               // Sum of 128 results
    localparam logic [7:0] SEARCH_START = 8'h80;  // First probe of search
    localparam logic [2:0] SEARCH_TOP = 3'h7;     // First bit under trial
    // ------------------------------------------------------------
    // Sequencer states, Gray along the path
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEARCH = 2'b01,
        ST_AVG = 2'b11,
        ST_FINISH = 2'b10
    } poc_state_t;
endpackage

// [rtl/poc_acc_if.sv]
`timescale 1ns/1ps
// Carries control and sum between sequencer and accumulator
interface poc_acc_if;
    logic clr;                               // Clear sum
    logic add;                               // Add din this cycle
    logic [poc_pkg::ADC_W-1:0] din;          // Value to add
    logic [poc_pkg::SUM_W-1:0] sum;          // Running sum
    modport ctl (output clr, output add, output din, input sum);
    modport acc (input clr, input add, input din, output sum);
endinterface

// [rtl/poc_acc.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Accumulator for DC averaging
// ------------------------------------------------------------
module poc_acc (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control from sequencer
    poc_acc_if.acc bus
);
    logic [poc_pkg::SUM_W-1:0] sum_reg;  // Running sum

    // Clear wins over add so a restart never carries old data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sum_reg <= '0;
        end else if (bus.clr) begin
            sum_reg <= '0;
        end else if (bus.add) begin
            sum_reg <= sum_reg + poc_pkg::SUM_W'(bus.din);
        end
    end

    assign bus.sum = sum_reg;
endmodule

// [tb/poc_top_test.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the offset calibration sequencer
// ------------------------------------------------------------
module poc_top_test;
    localparam logic [13:0] TARGET = 14'h0100; // Search threshold chosen for this run
    localparam int TIMEOUT = 6000;             // Cycles; the tests need well under 2000
    logic core_clk = 1'b0;                     // 25 MHz core clock
    logic rst_b = 1'b0;                        // Held low at start
    logic reg_wr = 1'b0;                       // Register write strobe
    logic reg_rd = 1'b0;                       // Register read strobe
    logic [7:0] reg_addr = 8'h00;              // Register address
    logic [7:0] reg_wdata = 8'h00;             // Write data
    logic adc_valid = 1'b0;                    // Result strobe
    logic [13:0] adc_data = 14'h0000;          // Result value
    logic cal_irq_en = 1'b0;                   // Interrupt enable level
    logic flag_clr = 1'b0;                     // Flag clear pulse
    logic [7:0] reg_rdata;                     // Read data
    logic cal_done;                            // Done flag
    logic offset_lowered;                      // Trim flag
    logic cal_irq;                             // Interrupt
    logic [7:0] offset;                        // Offset result
    logic [13:0] prox_baseline;                // Baseline result
    logic [7:0] rd;                            // Last value read back
    logic [13:0] vals[$];                      // Results to feed
    int n_errors = 0;                          // Mismatches seen
    int num_checks = 0;                        // Comparisons made
    int cycles = 0;                            // Clock cycles run
    int sum;                                   // Expected accumulator

    // Free-running clock, 40 ns period
    always #20 core_clk = ~core_clk;

    poc_top #(.ADC_TARGET(TARGET)) poc_top_i (
        .CORE_CLK(core_clk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
        .ADC_VALID(adc_valid), .ADC_DATA(adc_data), .CAL_IRQ_EN(cal_irq_en),
        .FLAG_CLR(flag_clr), .CAL_DONE(cal_done), .OFFSET_LOWERED(offset_lowered),
        .CAL_IRQ(cal_irq), .OFFSET(offset), .PROX_BASELINE(prox_baseline)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    // Closing verdict, the one place the run ends
    task automatic stop_test();
        if (n_errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Compare one value; case inequality so unknowns never match
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: saw %h, expected %h", $time, what, seen, exp);
        end
    endtask

    // Step to just after the next rising edge, where all drives change
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // One write, then an idle cycle so strobes never rise and fall together
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask

    // Read data is registered: sample it one edge after the strobe is taken
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        tick();
        d = reg_rdata;
    endtask

    // Results go in back to back, one per cycle
    task automatic feed();
        foreach (vals[i]) begin
            adc_data = vals[i];
            adc_valid = 1'b1;
            tick();
        end
        adc_valid = 1'b0;
    endtask

    // Bounded wait for completion
    task automatic wait_done();
        int k;
        k = 0;
        while (cal_done !== 1'b1 && k < 20) begin
            tick();
            k++;
        end
        check(16'(cal_done), 16'h0001, "done flag");
    endtask

    // Flags clear on a one-cycle pulse
    task automatic pulse_clear();
        flag_clr = 1'b1;
        tick();
        flag_clr = 1'b0;
        tick();
    endtask

    // Hang guard: counts as a mismatch and closes the run
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == TIMEOUT) begin
            n_errors++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        #1;
        rst_b = 1'b1;
        // Reset values, reserved bits, unmapped place
        reg_read(8'h6A, rd);
        check(16'(rd), 16'h0000, "config reset");
        reg_read(8'h69, rd);
        check(16'(rd), 16'h0000, "idle control");
        check(16'(prox_baseline), 16'h0000, "baseline reset");
        reg_write(8'h6A, 8'hFF);
        reg_write(8'h55, 8'hFF);
        reg_read(8'h6A, rd);
        check(16'(rd), 16'h00CF, "config mask");
        reg_read(8'h55, rd);
        check(16'(rd), 16'h0000, "unmapped read");
        // Every nonzero count code, search skipped, baseline loaded
        cal_irq_en = 1'b1;
        for (int n = 1; n < 8; n++) begin
            vals.delete();
            sum = 0;
            for (int i = 0; i < (1 << n); i++) begin
                vals.push_back(14'(i * 3 + n));
                sum += i * 3 + n;
            end
            reg_write(8'h6A, 8'h88 | 8'(n));
            reg_write(8'h69, 8'h01);
            check(16'(cal_done), 16'h0000, "done cleared by start");
            reg_read(8'h69, rd);
            check(16'(rd), 16'h0001, "busy");
            feed();
            wait_done();
            check(16'(prox_baseline), 16'(sum >> n), "average");
            tick();
            check(16'(cal_irq), 16'h0001, "irq enabled");
        end
        reg_read(8'h69, rd);
        check(16'(rd), 16'h0000, "idle after done");
        // Search then code 0: offset found, no averaging, baseline kept
        cal_irq_en = 1'b0;
        pulse_clear();
        vals = '{14'h0200, 14'h0010, 14'h0200, 14'h0010, 14'h0200, 14'h0010, 14'h0200, 14'h0010};
        reg_write(8'h6A, 8'h80);
        reg_write(8'h69, 8'h01);
        feed();
        wait_done();
        check(16'(offset), 16'h00AA, "search result");
        check(16'(prox_baseline), 16'(sum >> 7), "no load on code 0");
        tick();
        check(16'(cal_irq), 16'h0000, "irq masked");
        // Skip with code 0 finishes at once and keeps the offset
        reg_write(8'h6A, 8'h88);
        reg_write(8'h69, 8'h01);
        wait_done();
        check(16'(offset), 16'h00AA, "offset kept on skip");
        // Zero result trims offset, averaging runs on to its count
        vals = '{14'h0040, 14'h0000, 14'h0040, 14'h0040};
        reg_write(8'h6A, 8'hCA);
        reg_write(8'h69, 8'h01);
        feed();
        wait_done();
        check(16'(offset), 16'h00A9, "offset trimmed");
        check(16'(offset_lowered), 16'h0001, "trim flag");
        check(16'(prox_baseline), 16'h0030, "average with zero");
        pulse_clear();
        check(16'(offset_lowered), 16'h0000, "trim flag cleared");
        check(16'(cal_done), 16'h0000, "done flag cleared");
        // Trim was seen above: keep the search skipped and rerun the averaging on clean data
        vals = '{14'h0040, 14'h0044, 14'h0048, 14'h004C};
        reg_write(8'h6A, 8'hCA);
        reg_write(8'h69, 8'h01);
        feed();
        wait_done();
        check(16'(offset), 16'h00A9, "offset kept on restart");
        check(16'(offset_lowered), 16'h0000, "no trim on restart");
        check(16'(prox_baseline), 16'h0046, "average after restart");
        // Stop mid-average: back to idle, no done, results kept
        vals = '{14'h0100, 14'h0100, 14'h0100};
        reg_write(8'h6A, 8'h8F);
        reg_write(8'h69, 8'h01);
        feed();
        reg_write(8'h69, 8'h00);
        reg_read(8'h69, rd);
        check(16'(rd), 16'h0000, "stopped");
        repeat (4) tick();
        check(16'(cal_done), 16'h0000, "no done after stop");
        check(16'(offset), 16'h00A9, "offset after stop");
        check(16'(prox_baseline), 16'h0046, "baseline after stop");
        stop_test();
    end
endmodule
